/* bench/rsap_host_model.sv */
`default_nettype none

// Behavioural host that frames transfers on the serial pins
module rsap_host_model
	import rsap_pkg::*;
#(
	parameter int unsigned HALF_CYC = 20
) (
	input  wire logic core_clk,
	input  wire logic spi_mode,
	input  wire logic dev_line,
	output logic      transfer_select,
	output logic      serial_clk,
	output logic      host_d,
	output logic      host_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic idle_q = 1'b0;

	// Pins at rest: no frame, host owns the data line
	initial begin
		transfer_select = 1'b0;
		serial_clk = 1'b0;
		host_d = 1'b0;
		host_oe = 1'b1;
	end

	// Step whole core cycles, landing just after the edge
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Clock settles at its idle level before the select rises
	task automatic start(input logic cpol);
		idle_q = cpol;
		serial_clk = cpol;
		wait_cyc(HALF_CYC);
		transfer_select = 1'b1;
		wait_cyc(HALF_CYC);
	endtask

	// One byte; when not driving, SPI keeps toggling junk on the input
	task automatic xbyte(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
		int idx;
		for (int i = 0; i < 8; i++) begin
			idx = spi_mode ? 7 - i : i;
			host_oe = drive | spi_mode;
			host_d = drive ? tx[idx] : ~host_d;
			wait_cyc(HALF_CYC);
			serial_clk = ~idle_q;
			rx[idx] = dev_line;
			wait_cyc(HALF_CYC);
			serial_clk = idle_q;
		end
	endtask

	// Close the frame; take the line back only once the device let go
	task automatic stop();
		wait_cyc(HALF_CYC);
		transfer_select = 1'b0;
		wait_cyc(HALF_CYC);
		host_oe = 1'b1;
	endtask

endmodule // rsap_host_model

`default_nettype wire

/* bench/tb.sv */
`default_nettype none

module tb
	import rsap_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        core_clk;
	logic        rst;
	logic        interface_select_strap;
	logic        write_lock;
	logic        transfer_select, serial_clk, host_d, host_oe, dev_line, serial_in;
	logic        serial_out, serial_out_oe, mem_rd_req, mem_wr_req, transfer_active;
	logic [7:0]  mem_addr, mem_rd_data, mem_wr_data;
	logic        last_q = 1'b0;
	logic [15:0] wr_q[$];
	int          num_errors = 0;
	int          samples_checked = 0;

	// ----------------------------------------------------------------
	// Clock, line and memory models
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// A released line never keeps its last level, so a late drive shows up
	always @(posedge core_clk) if (serial_out_oe) last_q <= serial_out;
	assign dev_line    = serial_out_oe ? serial_out : ~last_q;
	assign serial_in   = host_oe ? host_d : dev_line;
	assign mem_rd_data = mem_addr ^ 8'h5a; // Content is a known scramble of the address

	// Every accepted write is logged with its address
	always @(posedge core_clk) if (mem_wr_req === 1'b1) wr_q.push_back({mem_addr, mem_wr_data});

	rsap_port rsap_port_i (
		.core_clk(core_clk), .rst(rst), .interface_select_strap(interface_select_strap),
		.transfer_select(transfer_select), .serial_clk(serial_clk), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .write_lock(write_lock),
		.mem_addr(mem_addr), .mem_rd_req(mem_rd_req), .mem_rd_data(mem_rd_data),
		.mem_wr_req(mem_wr_req), .mem_wr_data(mem_wr_data), .transfer_active(transfer_active)
	);

	rsap_host_model rsap_host_model_i (
		.core_clk(core_clk), .spi_mode(interface_select_strap), .dev_line(dev_line),
		.transfer_select(transfer_select), .serial_clk(serial_clk), .host_d(host_d),
		.host_oe(host_oe)
	);

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Shared frames
	// ----------------------------------------------------------------
	// Two-byte read burst; a1 is where the address must step to
	task automatic read_two(input logic spi, input logic cpol, input logic [7:0] a0,
		input logic [7:0] a1);
		logic [7:0] rx;
		interface_select_strap = spi;
		rsap_host_model_i.start(cpol);
		check("active in frame", {15'h0, transfer_active}, 16'h1);
		rsap_host_model_i.xbyte(a0, 1'b1, rx);
		check("oe after address", {15'h0, serial_out_oe}, 16'h0);
		rsap_host_model_i.xbyte(8'h00, 1'b0, rx);
		check("read byte 0", {8'h0, rx}, {8'h0, a0 ^ 8'h5a});
		rsap_host_model_i.xbyte(8'h00, 1'b0, rx);
		check("read byte 1", {8'h0, rx}, {8'h0, a1 ^ 8'h5a});
		rsap_host_model_i.stop();
		check("oe after frame", {15'h0, serial_out_oe}, 16'h0);
		check("active after frame", {15'h0, transfer_active}, 16'h0);
	endtask

	// Two-byte write burst, optionally under the write lock
	task automatic write_two(input logic spi, input logic cpol, input logic [7:0] a0,
		input logic [7:0] a1, input logic lock);
		logic [7:0] rx;
		wr_q.delete();
		write_lock = lock;
		interface_select_strap = spi;
		rsap_host_model_i.start(cpol);
		rsap_host_model_i.xbyte(a0, 1'b1, rx);
		rsap_host_model_i.xbyte(8'ha5, 1'b1, rx);
		rsap_host_model_i.xbyte(8'h3c, 1'b1, rx);
		check("oe in write", {15'h0, serial_out_oe}, 16'h0);
		check("active in write", {15'h0, transfer_active}, 16'h1);
		rsap_host_model_i.stop();
		if (lock) begin
			check("locked writes", 16'(wr_q.size()), 16'h0);
		end else begin
			check("write count", 16'(wr_q.size()), 16'h2);
			check("write 0", wr_q[0], {a0, 8'ha5});
			check("write 1", wr_q[1], {a1, 8'h3c});
		end
		write_lock = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic spi_read_clock_wrap();
		read_two(1'b1, 1'b0, 8'h1f, 8'h00);
	endtask

	task automatic spi_read_high_idle();
		read_two(1'b1, 1'b1, 8'h3a, 8'h3b);
	endtask

	task automatic spi_write_ram_wrap();
		write_two(1'b1, 1'b1, 8'hff, 8'ha0, 1'b0);
	endtask

	task automatic wire3_read_ram_wrap();
		read_two(1'b0, 1'b0, 8'h7f, 8'h20);
	endtask

	task automatic wire3_write_clock_wrap();
		write_two(1'b0, 1'b0, 8'h9f, 8'h80, 1'b0);
	endtask

	task automatic locked_write();
		write_two(1'b1, 1'b0, 8'h85, 8'h86, 1'b1);
	endtask

	// Frames take 1040 cycles each; the limit leaves ample margin
	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		interface_select_strap = 1'b1;
		write_lock = 1'b0;
		repeat (16) @(posedge core_clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		spi_read_clock_wrap();
		spi_read_high_idle();
		spi_write_ram_wrap();
		wire3_read_ram_wrap();
		wire3_write_clock_wrap();
		locked_write();
		end_of_test();
	end

endmodule // tb

`default_nettype wire

/* shared/rsap_pkg.sv */
`default_nettype none

package rsap_pkg;

	// ----------------------------------------------------------------
	// Framing
	// ----------------------------------------------------------------
	localparam int unsigned RSAP_BYTE_BITS = 8;
	localparam int unsigned RSAP_CNT_W     = 3;
	localparam logic [RSAP_CNT_W-1:0] RSAP_CNT_LAST  = 3'h7;
	localparam logic [RSAP_CNT_W-1:0] RSAP_CNT_RESET = 3'h0;

	// Position of the direction bit inside the address byte
	localparam int unsigned RSAP_DIR_POS = 7;

	// ----------------------------------------------------------------
	// Address wrap points
	// ----------------------------------------------------------------
	localparam logic [7:0] RSAP_CLK_RD_LAST  = 8'h1f;
	localparam logic [7:0] RSAP_CLK_RD_FIRST = 8'h00;
	localparam logic [7:0] RSAP_CLK_WR_LAST  = 8'h9f;
	localparam logic [7:0] RSAP_CLK_WR_FIRST = 8'h80;
	localparam logic [7:0] RSAP_RAM_RD_LAST  = 8'h7f;
	localparam logic [7:0] RSAP_RAM_RD_FIRST = 8'h20;
	localparam logic [7:0] RSAP_RAM_WR_LAST  = 8'hff;
	localparam logic [7:0] RSAP_RAM_WR_FIRST = 8'ha0;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] RSAP_BYTE_RESET = 8'h00;
	localparam logic       RSAP_BIT_RESET  = 1'b0;

	// Number of pin signals passed through the synchroniser
	localparam int unsigned RSAP_SYNC_W = 4;

	// ----------------------------------------------------------------
	// Transfer state, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		RSAP_ST_IDLE  = 4'b0001,
		RSAP_ST_ADDR  = 4'b0010,
		RSAP_ST_WDATA = 4'b0100,
		RSAP_ST_RDATA = 4'b1000
	} rsap_state_t;

endpackage : rsap_pkg

`default_nettype wire

/* verilog/rsap_port.sv */
// Overview of operation
// - Strap high selects four-wire SPI slave; strap low selects three-wire shared line.
// - Host frames each transfer with the select; this port is always the slave.
// - SPI mode samples clock level at select rise as idle polarity.
// - SPI latches input on strobe edge, shifts output on opposite edge, eight-bit bytes.
// - Read output stays high impedance until a byte is ready; input ignored meanwhile.
// - SPI mode shifts address and data most significant bit first.
// - First byte after select rise is the address, data bytes follow.
// - Address top bit is direction: zero reads, one writes.
// - Single transfer moves one byte; burst continues while select stays high.
// - Address increments after every data byte until the select falls.
// - Clock area wraps 1Fh to 00h on reads, 9Fh to 80h on writes.
// - RAM area wraps 7Fh to 20h on reads, FFh to A0h on writes.
// - Three-wire mode joins input and output into one bidirectional line.
// - Three-wire mode shifts every byte least significant bit first.
// - Three-wire frames are address then one or more data bytes, as SPI.
// - Three-wire captures on rising clock, drives after falling clock.
// - While write lock is set, every write data byte is dropped.
`default_nettype none

module rsap_port
	import rsap_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       interface_select_strap,
	input  wire logic       transfer_select,
	input  wire logic       serial_clk,
	input  wire logic       serial_in,
	output logic            serial_out,
	output logic            serial_out_oe,
	input  wire logic       write_lock,
	output logic [7:0]      mem_addr,
	output logic            mem_rd_req,
	input  wire logic [7:0] mem_rd_data,
	output logic            mem_wr_req,
	output logic [7:0]      mem_wr_data,
	output logic            transfer_active
);

	// ----------------------------------------------------------------
	// Address step with area wrap
	// ----------------------------------------------------------------
	// Reads live in 00h-7Fh and writes in 80h-FFh, so one table serves both
	function automatic logic [7:0] rsap_next_addr(input logic [7:0] a);
		logic [7:0] n;
		n = a + 8'h01;
		case (a)
			RSAP_CLK_RD_LAST: n = RSAP_CLK_RD_FIRST;
			RSAP_CLK_WR_LAST: n = RSAP_CLK_WR_FIRST;
			RSAP_RAM_RD_LAST: n = RSAP_RAM_RD_FIRST;
			RSAP_RAM_WR_LAST: n = RSAP_RAM_WR_FIRST;
			default:          n = a + 8'h01;
		endcase
		return n;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ----------------------------------------------------------------
	logic [RSAP_SYNC_W-1:0] pins_s;
	logic                   strap_s;
	logic                   ce_s;
	logic                   sclk_s;
	logic                   sin_s;
	logic                   ce_p_q;
	logic                   sclk_p_q;

	// Clock and data go through equal stages so bits stay aligned with edges
	rsap_sync #(
		.WIDTH (RSAP_SYNC_W)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in ({interface_select_strap, transfer_select, serial_clk, serial_in}),
		.sync_out (pins_s)
	);

	assign strap_s = pins_s[3];
	assign ce_s    = pins_s[2];
	assign sclk_s  = pins_s[1];
	assign sin_s   = pins_s[0];

	// Previous levels for edge finding
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ce_p_q   <= RSAP_BIT_RESET;
			sclk_p_q <= RSAP_BIT_RESET;
		end else begin
			ce_p_q   <= ce_s;
			sclk_p_q <= sclk_s;
		end
	end

	logic ce_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic strobe;
	logic shift;
	logic spi_q;
	logic idle_pol_q;

	assign ce_rise   = ce_s & ~ce_p_q;
	assign sclk_rise = sclk_s & ~sclk_p_q;
	assign sclk_fall = ~sclk_s & sclk_p_q;

	// Strobe is the edge leaving idle; edges are ignored with select low
	assign strobe = ce_s & ~ce_rise & (idle_pol_q ? sclk_fall : sclk_rise);
	assign shift  = ce_s & ~ce_rise & (idle_pol_q ? sclk_rise : sclk_fall);

	// ----------------------------------------------------------------
	// Mode and polarity capture
	// ----------------------------------------------------------------
	// Strap is taken per frame, so a strap change mid-frame cannot tear it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			spi_q      <= RSAP_BIT_RESET;
			idle_pol_q <= RSAP_BIT_RESET;
		end else if (ce_rise) begin
			spi_q      <= strap_s;
			idle_pol_q <= strap_s ? sclk_s : 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Receive shifter and bit counter
	// ----------------------------------------------------------------
	rsap_state_t                 state_q;
	logic [7:0]                  rx_q;
	logic [7:0]                  rx_d;
	logic [RSAP_CNT_W-1:0]       cnt_q;
	logic                        byte_done;

	// MSB first for SPI, LSB first for the shared line
	always_comb begin
		rx_d = spi_q ? {rx_q[6:0], sin_s} : {sin_s, rx_q[7:1]};
	end

	assign byte_done = strobe & (cnt_q == RSAP_CNT_LAST);

	// Counter counts strobes in every phase; select low clears it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= RSAP_CNT_RESET;
		end else if (!ce_s) begin
			cnt_q <= RSAP_CNT_RESET;
		end else if (strobe) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end

	// Input is only shifted while address or write data comes in
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_q <= RSAP_BYTE_RESET;
		end else if (!ce_s) begin
			rx_q <= RSAP_BYTE_RESET;
		end else if (strobe && (state_q != RSAP_ST_RDATA)) begin
			rx_q <= rx_d;
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencing
	// ----------------------------------------------------------------
	logic [7:0] addr_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= RSAP_ST_IDLE;
		end else if (!ce_s) begin
			state_q <= RSAP_ST_IDLE;
		end else begin
			case (state_q)
				RSAP_ST_IDLE: begin
					if (ce_rise) begin
						state_q <= RSAP_ST_ADDR;
					end
				end
				RSAP_ST_ADDR: begin
					if (byte_done) begin
						state_q <= rx_d[RSAP_DIR_POS] ? RSAP_ST_WDATA : RSAP_ST_RDATA;
					end
				end
				RSAP_ST_WDATA: state_q <= RSAP_ST_WDATA;
				RSAP_ST_RDATA: state_q <= RSAP_ST_RDATA;
				default:       state_q <= RSAP_ST_IDLE;
			endcase
		end
	end

	// Current location; steps after every data byte for burst
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_q <= RSAP_BYTE_RESET;
		end else if (byte_done && (state_q == RSAP_ST_ADDR)) begin
			addr_q <= rx_d;
		end else if (byte_done && (state_q != RSAP_ST_IDLE)) begin
			addr_q <= rsap_next_addr(addr_q);
		end
	end

	// ----------------------------------------------------------------
	// Memory side requests
	// ----------------------------------------------------------------
	logic rd_go;
	logic load_q;

	// A fetch starts after a read address and after each byte sent out
	assign rd_go = byte_done &&
		(((state_q == RSAP_ST_ADDR) && !rx_d[RSAP_DIR_POS]) || (state_q == RSAP_ST_RDATA));

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_addr    <= RSAP_BYTE_RESET;
			mem_rd_req  <= RSAP_BIT_RESET;
			mem_wr_req  <= RSAP_BIT_RESET;
			mem_wr_data <= RSAP_BYTE_RESET;
			load_q      <= RSAP_BIT_RESET;
		end else begin
			mem_rd_req <= rd_go;
			mem_wr_req <= 1'b0;
			load_q     <= mem_rd_req;
			if (rd_go) begin
				mem_addr <= (state_q == RSAP_ST_ADDR) ? rx_d : rsap_next_addr(addr_q);
			end
			if (byte_done && (state_q == RSAP_ST_WDATA)) begin
				mem_addr    <= addr_q;
				mem_wr_data <= rx_d;
				mem_wr_req  <= !write_lock;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit shifter and pin drive
	// ----------------------------------------------------------------
	logic [7:0] tx_q;
	logic       tx_valid_q;

	// Read data sits one cycle behind the fetch strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_q       <= RSAP_BYTE_RESET;
			tx_valid_q <= RSAP_BIT_RESET;
		end else if (!ce_s) begin
			tx_valid_q <= 1'b0;
		end else if (load_q) begin
			tx_q       <= mem_rd_data;
			tx_valid_q <= 1'b1;
		end else if (shift && tx_valid_q && (state_q == RSAP_ST_RDATA)) begin
			tx_q <= spi_q ? {tx_q[6:0], 1'b0} : {1'b0, tx_q[7:1]};
		end
	end

	// Drive starts on the first shift edge with a full byte waiting
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serial_out    <= RSAP_BIT_RESET;
			serial_out_oe <= RSAP_BIT_RESET;
		end else if (!ce_s) begin
			serial_out_oe <= 1'b0;
		end else if (shift && tx_valid_q && (state_q == RSAP_ST_RDATA)) begin
			serial_out    <= spi_q ? tx_q[7] : tx_q[0];
			serial_out_oe <= 1'b1;
		end
	end

	// The shared line is only driven in read phase, so no contention with host
	assign transfer_active = (state_q != RSAP_ST_IDLE);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_frame_open;
		$rose(ce_s) ##1 (state_q == RSAP_ST_ADDR);
	endsequence

	sequence s_addr_byte;
		(state_q == RSAP_ST_ADDR) && byte_done;
	endsequence

	sequence s_rd_data_byte;
		(state_q == RSAP_ST_RDATA) && byte_done;
	endsequence

	mode_capture_a: assert property ($rose(ce_s) |=> spi_q == $past(strap_s))
		else $error("mode not taken from strap at frame start");

	idle_polarity_a: assert property (
		($rose(ce_s) && strap_s) |=> idle_pol_q == $past(sclk_s))
		else $error("idle polarity not sampled at select rise");

	addr_first_a: assert property ($rose(ce_s) |=> (state_q == RSAP_ST_ADDR))
		else $error("frame did not open in address phase");

	direction_bit_a: assert property (s_addr_byte |=>
		(state_q == ($past(rx_d[RSAP_DIR_POS]) ? RSAP_ST_WDATA : RSAP_ST_RDATA)))
		else $error("direction bit misrouted");

	read_fetch_a: assert property ((s_addr_byte and !rx_d[RSAP_DIR_POS]) or s_rd_data_byte
		|=> mem_rd_req ##1 !mem_rd_req ##1 tx_valid_q)
		else $error("read fetch not issued after byte");

	clock_wrap_a: assert property ((byte_done && (state_q == RSAP_ST_WDATA) &&
		(addr_q == RSAP_CLK_WR_LAST)) |=> addr_q == RSAP_CLK_WR_FIRST)
		else $error("clock area write wrap wrong");

	ram_wrap_a: assert property (s_rd_data_byte and (addr_q == RSAP_RAM_RD_LAST)
		|=> (addr_q == RSAP_RAM_RD_FIRST) && (mem_addr == RSAP_RAM_RD_FIRST))
		else $error("ram area read wrap wrong");

	write_lock_a: assert property (mem_wr_req |-> !$past(write_lock) &&
		($past(state_q) == RSAP_ST_WDATA))
		else $error("write issued while locked or outside write phase");

	out_hold_a: assert property (serial_out_oe |-> (state_q == RSAP_ST_RDATA) && tx_valid_q)
		else $error("output driven without a ready byte");

	deselect_off_a: assert property (!ce_s |=> !serial_out_oe && (cnt_q == RSAP_CNT_RESET)
		&& (state_q == RSAP_ST_IDLE))
		else $error("port not reset by low select");

	three_wire_edge_a: assert property ((ce_s && !spi_q && !ce_rise) |->
		(strobe == sclk_rise) && (shift == sclk_fall))
		else $error("three-wire edges wrong");

	open_seq_a: assert property ($rose(ce_s) |-> s_frame_open)
		else $error("frame opening sequence broken");

endmodule // rsap_port

`default_nettype wire

/* verilog/rsap_sync.sv */
`default_nettype none

// Two-stage synchroniser for a group of unrelated pin levels
module rsap_sync
	import rsap_pkg::*;
#(
	parameter int unsigned WIDTH = RSAP_SYNC_W
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// ----------------------------------------------------------------
	// Stages
	// ----------------------------------------------------------------
	// First stage feeds only the second one, never any logic
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // rsap_sync

`default_nettype wire
